// file: hdl/acc_map.vh
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// Register indexes; byte address is four times the index
`define ACC_IDX_RES_LOW 8'h78
`define ACC_IDX_RES_HIGH 8'h79
`define ACC_IDX_CTRL 8'h7A
`define ACC_IDX_SEL 8'h7C

// Reset values
`define ACC_CTRL_RESET 8'h00
`define ACC_SEL_RESET 8'h00
`define ACC_RES_RESET 10'h000

// Control/status field positions
`define ACC_CTRL_EN 7
`define ACC_CTRL_START 6
`define ACC_CTRL_ATE 5
`define ACC_CTRL_FLAG 4
`define ACC_CTRL_IE 3
`define ACC_CTRL_PS_HI 2
`define ACC_CTRL_PS_LO 0

// Input select field positions
`define ACC_SEL_REF_HI 7
`define ACC_SEL_REF_LO 6
`define ACC_SEL_LA 5
`define ACC_SEL_CH_HI 4
`define ACC_SEL_CH_LO 0

// Conversion lengths in converter clock cycles
`define ACC_FIRST_CYCLES 5'h19
`define ACC_NORMAL_CYCLES 5'h0D

// Channel code landmarks
`define ACC_CH_DIFF_LO 5'h08
`define ACC_CH_DIFF_1X 5'h10
`define ACC_CH_DIFF_HI 5'h1D
`define ACC_CH_BANDGAP 5'h1E
`define ACC_CH_GROUND 5'h1F

// Gain codes on the front-end port
`define ACC_GAIN_1X 2'h0
`define ACC_GAIN_10X 2'h1
`define ACC_GAIN_200X 2'h2

// Differential full-scale codes
`define ACC_DIFF_POS_FS 10'h1FF
`define ACC_DIFF_NEG_FS 10'h200

// Reference codes
`define ACC_REF_EXTERNAL 2'h0

`endif

// file: hdl/acc_prescaler.v
`timescale 1ns/1ps
`default_nettype none

module acc_prescaler
(
   input wire core_clk_in, // System clock
   input wire rst_in, // Synchronous reset, active high
   input wire run_in, // Count only while converting
   input wire [2:0] prescaler_in, // Division select
   output wire tick_out // One system cycle per converter clock
);

   reg [6:0] count_reg; // Divider count
   wire [6:0] mask; // Division factor minus one

   // Factors 2,2,4,8,...,128
   assign mask = (prescaler_in == 3'h0) ? 7'h01 :
      (7'h7F >> (3'h7 - prescaler_in));

   // Tick at the end of each divided period
   assign tick_out = run_in && (count_reg >= mask);

   // Counter restarts from zero at each conversion
   always @(posedge core_clk_in)
   begin
      if (rst_in || !run_in)
      begin
         count_reg <= 7'h00;
      end
      else if (count_reg >= mask)
      begin
         count_reg <= 7'h00;
      end
      else
      begin
         count_reg <= count_reg + 7'h01;
      end
   end

endmodule

`default_nettype wire

// file: hdl/acc_converter.v
// Overview of operation
// - Differential results coded ten-bit two's complement
// - Reference change waits for conversion completion
// - Reference code: external, supply, 1.1V, 2.56V
// - Left-adjust bit selects result alignment
// - Alignment change applies immediately, always
// - Codes 0-7 single, 1E bandgap, 1F ground
// - Codes 08-0F gained pairs, 10-1D unity
// - Channel change waits for conversion completion
// - Enable bit turns converter on and off
// - Clearing enable aborts conversion, no result, except in its last cycle, when flag and result are still delivered
// - Input select register at 0x7C, reset zero
// - Control/status register at 0x7A, reset zero
// - First conversion 25 cycles, others 13
// - Flag sets on completion, cleared by ack/one
// - Prescaler divides system clock 2 to 128
// - Low byte read locks result until high
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"

module acc_converter
(
   input wire core_clk_in, // System clock, 40 MHz
   input wire rst_in, // Synchronous reset, active high
   input wire wb_cyc_in, // Wishbone cycle
   input wire wb_stb_in, // Wishbone strobe
   input wire wb_we_in, // Wishbone write enable
   input wire [9:0] wb_adr_in, // Wishbone byte address
   input wire [3:0] wb_sel_in, // Wishbone byte selects
   input wire [31:0] wb_dat_in, // Wishbone write data
   output reg [31:0] wb_dat_out, // Wishbone read data
   output reg wb_ack_out, // Wishbone acknowledge
   input wire trig_in, // Auto-trigger source, asynchronous
   input wire irq_ack_in, // Interrupt vector taken, pulse
   input wire [10:0] afe_code_in, // Signed raw code from front end
   output reg afe_enable_out, // Front end powered
   output reg afe_sample_out, // Sample pulse at conversion start
   output reg [1:0] reference_select_out, // Active reference code
   output reg internal_ref_on_out, // Internal reference running
   output reg diff_mode_out, // Differential pair selected
   output reg [2:0] pos_chan_out, // Positive or single input
   output reg [2:0] neg_chan_out, // Negative input
   output reg [1:0] gain_out, // Gain code
   output reg bandgap_sel_out, // Bandgap input selected
   output reg ground_sel_out, // Ground input selected
   output wire busy_out, // Conversion running
   output wire done_req_out // Completion interrupt request
);

   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   localparam ST_IDLE = 1'b0; // No conversion
   localparam ST_CONV = 1'b1; // Conversion running
   localparam [7:0] RST_CTRL = `ACC_CTRL_RESET; // Control reset value
   localparam [7:0] RST_SEL = `ACC_SEL_RESET; // Select reset value

   reg state_reg; // Sequencer state
   reg enable_reg; // Converter enable
   reg auto_trig_reg; // Auto-trigger enable
   reg flag_reg; // Completion flag
   reg irq_en_reg; // Completion interrupt enable
   reg [2:0] prescaler_reg; // Prescaler select
   reg [1:0] ref_sel_reg; // Pending reference
   reg left_adj_reg; // Left-adjust result
   reg [4:0] chan_sel_reg; // Pending channel and gain
   reg [1:0] ref_act_reg; // Reference in use
   reg [4:0] chan_act_reg; // Channel in use
   reg first_reg; // Next conversion initialises
   reg [4:0] len_reg; // Length of running conversion
   reg [4:0] tick_cnt_reg; // Converter cycles elapsed
   reg [9:0] result_reg; // Latest delivered result
   reg lock_reg; // Result frozen after low byte read
   reg trig_meta_reg; // Trigger synchroniser stage one
   reg trig_sync_reg; // Trigger synchroniser stage two
   reg trig_last_reg; // Trigger for edge detection
   wire tick; // Converter clock tick
   wire bus_req; // Request present
   wire bus_take; // Request completes this edge
   wire bus_wr; // Write completes this edge
   wire bus_rd; // Read completes this edge
   wire [7:0] reg_idx; // Register index
   wire wr_ctrl; // Write to control/status
   wire wr_sel; // Write to input select
   wire enable_next; // Enable after this edge
   wire start_req; // Start wanted this edge
   wire conv_done; // Last cycle of conversion
   wire [15:0] data16; // Presented data register
   wire [7:0] ctrl_rd; // Control/status read value
   wire [7:0] sel_rd; // Input select read value
   wire [10:0] decoded; // Decoded channel selection

   //------------------------------------------------------------
   // Functions
   //------------------------------------------------------------
   // Channel decode: {diff, gain, pos, neg, bandgap, ground}
   function [10:0] acc_decode;
      input [4:0] ch;
      begin
         acc_decode = 11'h000;
         if (ch < `ACC_CH_DIFF_LO)
         begin
            acc_decode = {1'b0, `ACC_GAIN_1X, ch[2:0], 5'h00};
         end
         else if (ch < `ACC_CH_DIFF_1X)
         begin
            acc_decode = {1'b1,
               (ch[1] ? `ACC_GAIN_200X : `ACC_GAIN_10X),
               {1'b0, ch[2], ch[0]}, {1'b0, ch[2], 1'b0}, 2'h0};
         end
         else if (ch <= `ACC_CH_DIFF_HI)
         begin
            acc_decode = {1'b1, `ACC_GAIN_1X, ch[2:0],
               (ch[3] ? 3'h2 : 3'h1), 2'h0};
         end
         else if (ch == `ACC_CH_BANDGAP)
         begin
            acc_decode = 11'h002;
         end
         else
         begin
            acc_decode = 11'h001;
         end
      end
   endfunction

   // Clamp raw code into the delivered ten-bit coding
   function [9:0] acc_code;
      input diff;
      input [10:0] raw;
      begin
         acc_code = raw[9:0];
         if (diff)
         begin
            if (!raw[10] && raw[9])
            begin
               acc_code = `ACC_DIFF_POS_FS;
            end
            else if (raw[10] && !raw[9])
            begin
               acc_code = `ACC_DIFF_NEG_FS;
            end
         end
         else if (raw[10])
         begin
            acc_code = 10'h000;
         end
      end
   endfunction

   //------------------------------------------------------------
   // Bus decode
   //------------------------------------------------------------
   assign bus_req = wb_cyc_in && wb_stb_in;
   assign bus_take = bus_req && wb_ack_out;
   assign bus_wr = bus_take && wb_we_in && wb_sel_in[0];
   assign bus_rd = bus_take && !wb_we_in;
   assign reg_idx = wb_adr_in[9:2];
   assign wr_ctrl = bus_wr && (reg_idx == `ACC_IDX_CTRL);
   assign wr_sel = bus_wr && (reg_idx == `ACC_IDX_SEL);

   // Enable follows software writes
   assign enable_next = wr_ctrl ? wb_dat_in[`ACC_CTRL_EN] :
      enable_reg;

   // Start by software or by a trigger edge
   assign start_req = enable_next && (state_reg == ST_IDLE) &&
      ((wr_ctrl && wb_dat_in[`ACC_CTRL_START]) ||
      (auto_trig_reg && trig_sync_reg && !trig_last_reg));

   assign conv_done = (state_reg == ST_CONV) && tick &&
      (tick_cnt_reg == len_reg - 5'h01);

   // Alignment straight from the register bit
   assign data16 = left_adj_reg ? {result_reg, 6'h00} :
      {6'h00, result_reg};

   assign busy_out = (state_reg == ST_CONV);
   assign done_req_out = flag_reg && irq_en_reg;
   assign ctrl_rd = {enable_reg, busy_out, auto_trig_reg, flag_reg,
      irq_en_reg, prescaler_reg};
   assign sel_rd = {ref_sel_reg, left_adj_reg, chan_sel_reg};
   assign decoded = acc_decode(chan_act_reg);

   //------------------------------------------------------------
   // Converter clock divider
   //------------------------------------------------------------
   acc_prescaler u_prescaler
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .run_in(state_reg == ST_CONV),
      .prescaler_in(prescaler_reg),
      .tick_out(tick)
   );

   //------------------------------------------------------------
   // Bus slave
   //------------------------------------------------------------
   // One wait state, ack for one cycle, zero for unmapped
   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end
      else
      begin
         wb_ack_out <= bus_req && !wb_ack_out;
         if (reg_idx == `ACC_IDX_RES_LOW)
         begin
            wb_dat_out <= {24'h000000, data16[7:0]};
         end
         else if (reg_idx == `ACC_IDX_RES_HIGH)
         begin
            wb_dat_out <= {24'h000000, data16[15:8]};
         end
         else if (reg_idx == `ACC_IDX_CTRL)
         begin
            wb_dat_out <= {24'h000000, ctrl_rd};
         end
         else if (reg_idx == `ACC_IDX_SEL)
         begin
            wb_dat_out <= {24'h000000, sel_rd};
         end
         else
         begin
            wb_dat_out <= 32'h00000000;
         end
      end
   end

   //------------------------------------------------------------
   // Trigger synchroniser
   //------------------------------------------------------------
   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         trig_meta_reg <= 1'b0;
         trig_sync_reg <= 1'b0;
         trig_last_reg <= 1'b0;
      end
      else
      begin
         trig_meta_reg <= trig_in;
         trig_sync_reg <= trig_meta_reg;
         trig_last_reg <= trig_sync_reg;
      end
   end

   //------------------------------------------------------------
   // Registers written by software
   //------------------------------------------------------------
   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         {enable_reg, auto_trig_reg, irq_en_reg, prescaler_reg} <=
            {RST_CTRL[7], RST_CTRL[5], RST_CTRL[3],
            RST_CTRL[2:0]};
         {ref_sel_reg, left_adj_reg, chan_sel_reg} <=
            RST_SEL;
      end
      else
      begin
         enable_reg <= enable_next;
         if (wr_ctrl)
         begin
            auto_trig_reg <= wb_dat_in[`ACC_CTRL_ATE];
            irq_en_reg <= wb_dat_in[`ACC_CTRL_IE];
            prescaler_reg <=
               wb_dat_in[`ACC_CTRL_PS_HI:`ACC_CTRL_PS_LO];
         end
         if (wr_sel)
         begin
            ref_sel_reg <= wb_dat_in[`ACC_SEL_REF_HI:`ACC_SEL_REF_LO];
            left_adj_reg <= wb_dat_in[`ACC_SEL_LA];
            chan_sel_reg <= wb_dat_in[`ACC_SEL_CH_HI:`ACC_SEL_CH_LO];
         end
      end
   end

   //------------------------------------------------------------
   // Completion flag, set wins over clear
   //------------------------------------------------------------
   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         flag_reg <= RST_CTRL[4];
      end
      else if (conv_done)
      begin
         flag_reg <= 1'b1;
      end
      else if (irq_ack_in || (wr_ctrl && wb_dat_in[`ACC_CTRL_FLAG]))
      begin
         flag_reg <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // Conversion sequencer
   //------------------------------------------------------------
   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         state_reg <= ST_IDLE;
         first_reg <= 1'b1;
         len_reg <= `ACC_NORMAL_CYCLES;
         tick_cnt_reg <= 5'h00;
         afe_sample_out <= 1'b0;
      end
      else
      begin
         afe_sample_out <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               tick_cnt_reg <= 5'h00;
               if (!enable_next)
               begin
                  first_reg <= 1'b1;
               end
               else if (start_req)
               begin
                  state_reg <= ST_CONV;
                  len_reg <= first_reg ? `ACC_FIRST_CYCLES :
                     `ACC_NORMAL_CYCLES;
                  first_reg <= 1'b0;
                  afe_sample_out <= 1'b1;
               end
            end
            ST_CONV:
            begin
               if (!enable_next)
               begin
                  state_reg <= ST_IDLE;
                  first_reg <= 1'b1;
               end
               else if (conv_done)
               begin
                  state_reg <= ST_IDLE;
               end
               else if (tick)
               begin
                  tick_cnt_reg <= tick_cnt_reg + 5'h01;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   //------------------------------------------------------------
   // Selections in use: frozen while converting
   //------------------------------------------------------------
   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         ref_act_reg <= RST_SEL[7:6];
         chan_act_reg <= RST_SEL[4:0];
      end
      else if (state_reg == ST_IDLE && !start_req)
      begin
         ref_act_reg <= ref_sel_reg;
         chan_act_reg <= chan_sel_reg;
      end
   end

   //------------------------------------------------------------
   // Result capture and read lock
   //------------------------------------------------------------
   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         result_reg <= `ACC_RES_RESET;
         lock_reg <= 1'b0;
      end
      else
      begin
         if (conv_done && !lock_reg)
         begin
            result_reg <= acc_code(decoded[10], afe_code_in);
         end
         if (bus_rd && reg_idx == `ACC_IDX_RES_HIGH)
         begin
            lock_reg <= 1'b0;
         end
         else if (bus_rd && reg_idx == `ACC_IDX_RES_LOW)
         begin
            lock_reg <= 1'b1;
         end
      end
   end

   //------------------------------------------------------------
   // Front-end control outputs
   //------------------------------------------------------------
   always @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         afe_enable_out <= 1'b0;
         reference_select_out <= `ACC_REF_EXTERNAL;
         internal_ref_on_out <= 1'b0;
         {diff_mode_out, gain_out, pos_chan_out, neg_chan_out,
            bandgap_sel_out, ground_sel_out} <= 11'h000;
      end
      else
      begin
         afe_enable_out <= enable_reg;
         reference_select_out <= ref_act_reg;
         internal_ref_on_out <= (ref_act_reg != `ACC_REF_EXTERNAL);
         {diff_mode_out, gain_out, pos_chan_out, neg_chan_out,
            bandgap_sel_out, ground_sel_out} <= decoded;
      end
   end

endmodule

`default_nettype wire

// file: tb/acc_converter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"

module acc_converter_asserts
(
   input wire logic core_clk_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic wb_cyc_in, // Cycle
   input wire logic wb_stb_in, // Strobe
   input wire logic wb_we_in, // Write
   input wire logic [9:0] wb_adr_in, // Address
   input wire logic [3:0] wb_sel_in, // Selects
   input wire logic [31:0] wb_dat_in, // Write data
   input wire logic [31:0] wb_dat_out, // Read data
   input wire logic wb_ack_out, // Ack
   input wire logic irq_ack_in, // Vector taken
   input wire logic afe_enable_out, // Front end on
   input wire logic [1:0] reference_select_out, // Reference
   input wire logic diff_mode_out, // Differential
   input wire logic [2:0] pos_chan_out, // Positive
   input wire logic [2:0] neg_chan_out, // Negative
   input wire logic [1:0] gain_out, // Gain
   input wire logic bandgap_sel_out, // Bandgap
   input wire logic ground_sel_out, // Ground
   input wire logic busy_out, // Converting
   input wire logic done_req_out // Request
);
   // --------------------
   // Helpers
   // --------------------
   logic ie_reg; // Mirror of interrupt enable
   wire logic ctl_hit; // Control write taking effect
   wire logic [10:0] chan_bus; // All channel decode outputs
   assign ctl_hit = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in
      && wb_sel_in[0] && (wb_adr_in[9:2] == `ACC_IDX_CTRL);
   assign chan_bus = {diff_mode_out, pos_chan_out, neg_chan_out, gain_out,
      bandgap_sel_out, ground_sel_out};

   // Follow interrupt enable writes
   always @(posedge core_clk_in)
   begin
      if (rst_in)
         ie_reg <= 1'b0;
      else if (ctl_hit)
         ie_reg <= wb_dat_in[`ACC_CTRL_IE];
   end

   // --------------------
   // Properties
   // --------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_abort;
      busy_out && ctl_hit && !wb_dat_in[`ACC_CTRL_EN];
   endsequence
   sequence s_run_end;
      (busy_out && !(ctl_hit && !wb_dat_in[`ACC_CTRL_EN]))
      ##1 (!busy_out && ie_reg);
   endsequence
   property p_ack_one;
      wb_ack_out |=> !wb_ack_out;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   property p_enable;
      ctl_hit |-> ##2 (afe_enable_out == $past(wb_dat_in[7], 2));
   endproperty
   a_enable: assert property (p_enable) else $error("enable lost");
   property p_abort;
      s_abort |=> !busy_out ##1 !busy_out;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   property p_start_rd;
      wb_ack_out && !wb_we_in && (wb_adr_in[9:2] == `ACC_IDX_CTRL)
      |-> wb_dat_out[6] == $past(busy_out);
   endproperty
   a_start_rd: assert property (p_start_rd) else $error("start bit");
   property p_done;
      s_run_end |-> done_req_out;
   endproperty
   a_done: assert property (p_done) else $error("flag not set");
   property p_irq_clr;
      irq_ack_in && !busy_out |=> !done_req_out;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("flag kept");
   property p_ref_hold;
      busy_out [*3] |-> $stable(reference_select_out);
   endproperty
   a_ref_hold: assert property (p_ref_hold) else $error("ref moved");
   property p_chan_hold;
      busy_out [*3] |-> $stable(chan_bus);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("chan moved");
endmodule

`default_nettype wire

// file: tb/acc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none

module acc_afe_model
(
   input wire logic core_clk_in, // System clock
   input wire logic enable_in, // Front end powered
   input wire logic sample_in, // Sample pulse
   input wire logic [10:0] level_in, // Difference to convert
   output logic [10:0] code_out // Raw code
);
   // ------------------------------------------
   // Track and hold; only the code, never the reference pin
   // ------------------------------------------
   initial code_out = 11'h555;
   always @(posedge core_clk_in)
   begin
      if (sample_in)
         code_out <= level_in; // Hold until next sample
      else if (!enable_in)
         code_out <= ~code_out; // Unpowered: no stable code
   end
endmodule

`default_nettype wire

// file: tb/tb_analog_converter_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"

module tb_analog_converter_control;
   // --------------------
   // Bench signals, named as the ports
   // --------------------
   logic core_clk_in = 1'b0; // 40 MHz clock
   logic rst_in = 1'b1; // Reset
   logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0; // Bus
   logic [9:0] wb_adr_in = 10'h000; // Address
   logic [3:0] wb_sel_in = 4'h0; // Selects
   logic [31:0] wb_dat_in = 32'h00000000; // Write data
   logic trig_in = 1'b0, irq_ack_in = 1'b0; // Trigger, vector
   logic [10:0] level = 11'h000; // Input to front end
   wire logic [31:0] wb_dat_out; // Read data
   wire logic [10:0] afe_code_in; // Front end code
   wire logic [1:0] reference_select_out, gain_out; // Ref, gain
   wire logic [2:0] pos_chan_out, neg_chan_out; // Channels
   wire logic wb_ack_out, afe_enable_out, afe_sample_out; // Flags
   wire logic internal_ref_on_out, diff_mode_out; // Decode
   wire logic bandgap_sel_out, ground_sel_out, busy_out, done_req_out; // Status
   int mismatches = 0; // Failed comparisons
   int num_checks = 0; // All comparisons
   logic [31:0] seed = 32'h00015401; // Xorshift state
   logic [7:0] q; // Last read byte
   logic [18:0] cor [8] = '{{8'hD0, 11'h1FF}, {8'hF0, 11'h7FF},
      {8'hD0, 11'h600}, {8'hD0, 11'h3FF}, {8'hF0, 11'h400},
      {8'hC0, 11'h3FF}, {8'hE0, 11'h700}, {8'hD0, 11'h000}}; // Corners

   always #12.5 core_clk_in = ~core_clk_in;

   acc_converter acc_converter_inst (.*);
   acc_afe_model acc_afe_model_inst
   (
      .core_clk_in, .enable_in(afe_enable_out), .sample_in(afe_sample_out),
      .level_in(level), .code_out(afe_code_in)
   );

   // --------------------
   // Expectations
   // --------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Ten-bit result; pairs saturate, single clamps at zero
   function automatic logic [9:0] exp_res(input logic d, input logic [10:0] r);
      if (!d)
         return r[10] ? 10'h000 : r[9:0];
      else if (r[10] != r[9])
         return r[10] ? 10'h200 : 10'h1FF;
      return r[9:0];
   endfunction
   // Decode {diff, pos, neg, gain, bandgap, ground}
   function automatic logic [10:0] exp_dec(input logic [4:0] c);
      if (c < 5'h08)
         return {1'b0, c[2:0], 7'h00};
      if (c < 5'h10)
         return {2'b10, c[2], c[0], 1'b0, c[2], 1'b0,
            c[1] ? `ACC_GAIN_200X : `ACC_GAIN_10X, 2'b00};
      if (c < 5'h1E)
         return {1'b1, c[2:0], c[3] ? 3'h2 : 3'h1, `ACC_GAIN_1X, 2'b00};
      return {9'h000, c == 5'h1E, c == 5'h1F};
   endfunction

   // --------------------
   // Bus and compare tasks
   // --------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] r);
      @(posedge core_clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= {a, 2'b00};
      wb_sel_in <= 4'h1;
      wb_dat_in <= {24'h000000, d};
      @(posedge core_clk_in);
      while (wb_ack_out !== 1'b1)
         @(posedge core_clk_in);
      r = wb_dat_out[7:0];
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   task automatic idle(output int n);
      n = 0;
      @(posedge core_clk_in);
      while (busy_out === 1'b1 && n < 20000)
      begin
         n++;
         @(posedge core_clk_in);
      end
   endtask
   // One conversion, then length, flag and aligned result
   task automatic run(input logic [7:0] v, input logic [10:0] r,
      input logic [2:0] ps, input int len);
      int n;
      logic [9:0] res;
      res = exp_res((v[4:0] >= 5'h08) && (v[4:0] < 5'h1E), r);
      level <= r;
      wr(`ACC_IDX_SEL, v);
      wr(`ACC_IDX_CTRL, 8'hC0 | ps);
      idle(n);
      chk(n, 16'(len * ((ps < 3'h2) ? 2 : (1 << ps))));
      rdc(`ACC_IDX_CTRL, 8'h90 | ps);
      wr(`ACC_IDX_CTRL, 8'h90 | ps);
      rdc(`ACC_IDX_CTRL, 8'h80 | ps);
      rdc(`ACC_IDX_RES_LOW, v[5] ? {res[1:0], 6'h00} : res[7:0]);
      rdc(`ACC_IDX_RES_HIGH, v[5] ? res[9:2] : {6'h00, res[9:8]});
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // --------------------
   // Test sequence
   // --------------------
   initial
   begin
      logic [7:0] v;
      logic [10:0] e;
      logic [10:0] m;
      logic [31:0] x;
      int n;
      repeat (6) @(posedge core_clk_in);
      rst_in <= 1'b0;
      rdc(`ACC_IDX_CTRL, 8'h00);
      rdc(`ACC_IDX_SEL, 8'h00);
      wr(8'h70, 8'hFF);
      rdc(8'h70, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 32; i++)
      begin
         x = xs();
         v = {(i < 8 || i > 29) ? i[1:0] : 2'h3, x[9], i[4:0]};
         wr(`ACC_IDX_SEL, v);
         rdc(`ACC_IDX_SEL, v);
         e = exp_dec(i[4:0]);
         m = e[10] ? 11'h7FF : ((i > 29) ? 11'h403 : 11'h783);
         chk(reference_select_out, v[7:6]);
         chk(internal_ref_on_out, v[7:6] != 2'h0);
         chk({diff_mode_out, pos_chan_out, neg_chan_out, gain_out,
            bandgap_sel_out, ground_sel_out} & m, e & m);
      end
      $display("test decode done");
      for (int i = 0; i < 14; i++)
      begin
         x = xs();
         v = (i < 8) ? cor[i][18:11] : {2'h3, x[5], 5'(x[15:8] % 8'h1E)};
         e = (i < 8) ? cor[i][10:0] : x[26:16];
         run(v, e, (i < 8) ? i[2:0] : x[2:0], (i == 0) ? 25 : 13);
      end
      $display("test conversions done");
      run(8'hD0, 11'h0AB, 3'h0, 13);
      rdc(`ACC_IDX_RES_LOW, 8'hAB);
      level <= 11'h055;
      wr(`ACC_IDX_CTRL, 8'hC0);
      wr(`ACC_IDX_SEL, 8'h38);
      chk(reference_select_out, 2'h3);
      chk(neg_chan_out, 3'h1);
      rdc(`ACC_IDX_RES_LOW, 8'hC0);
      idle(n);
      rdc(`ACC_IDX_CTRL, 8'h90);
      chk(reference_select_out, 2'h0);
      rdc(`ACC_IDX_RES_HIGH, 8'h2A);
      rdc(`ACC_IDX_RES_LOW, 8'hC0);
      wr(`ACC_IDX_CTRL, 8'h90);
      wr(`ACC_IDX_CTRL, 8'hC0);
      wr(`ACC_IDX_CTRL, 8'h00);
      rdc(`ACC_IDX_CTRL, 8'h00);
      chk(busy_out, 1'b0);
      chk(afe_enable_out, 1'b0);
      rdc(`ACC_IDX_RES_LOW, 8'hC0);
      $display("test lock and abort done");
      wr(`ACC_IDX_CTRL, 8'hA8);
      trig_in <= 1'b1;
      for (n = 0; n < 20 && busy_out !== 1'b1; n++)
         @(posedge core_clk_in);
      chk(busy_out, 1'b1);
      trig_in <= 1'b0;
      idle(n);
      chk(done_req_out, 1'b1);
      irq_ack_in <= 1'b1;
      @(posedge core_clk_in);
      irq_ack_in <= 1'b0;
      @(posedge core_clk_in);
      chk(done_req_out, 1'b0);
      rdc(`ACC_IDX_CTRL, 8'hA8);
      $display("test trigger done");
      test_done();
   end

   // Cut a hang short
   initial
   begin
      repeat (80000) @(posedge core_clk_in);
      mismatches++;
      test_done();
   end
endmodule

bind acc_converter acc_converter_asserts acc_converter_asserts_inst (.*);

`default_nettype wire
